/* File: design/nand_host_regs.svh */
/*
  Command bytes, address layout and strobe timing counts for the NAND host
  sequencer. Assumes a 200 MHz sequencer clock.
*/
`ifndef NAND_HOST_REGS_SVH
`define NAND_HOST_REGS_SVH

`define CMD_READ_SETUP  8'h00
`define CMD_CB_READ     8'h35
`define CMD_RAND_OUT    8'h05
`define CMD_RAND_OUT_GO 8'he0
`define CMD_SERIAL_IN   8'h80
`define CMD_RAND_IN     8'h85
`define CMD_PROG_GO     8'h10
`define CMD_QUEUE_GO    8'h11
`define CMD_STATUS      8'h70
`define CMD_STATUS_ENH  8'h78
`define CMD_RESET       8'hff

`define PLANE_SEL_POS   6
`define PAGE_BYTES      16'h0880
`define STATUS_FAIL_MSK 8'h03
`define SEQ_LEN         9

`define CLK_MHZ         200
`define T_WE_LOW_NS     25
`define T_WE_HIGH_NS    15
`define T_RD_LOW_NS     25
`define T_RD_HIGH_NS    15
`define T_WB_NS         100
`define CYC(ns)         ((((ns) * `CLK_MHZ) + 999) / 1000)
`define WE_LOW_CYC      5'(`CYC(`T_WE_LOW_NS))
`define WE_HIGH_CYC     5'(`CYC(`T_WE_HIGH_NS))
`define RD_LOW_CYC      5'(`CYC(`T_RD_LOW_NS) + 2)
`define RD_HIGH_CYC     5'(`CYC(`T_RD_HIGH_NS))
`define WB_CYC          5'(`CYC(`T_WB_NS))

`endif

/* File: design/nand_host_pkg.sv */
/*
  Types for the NAND host sequencer: user orders, cycle kinds, pin bundle.
  Assumes nand_host_regs.svh for all numeric constants.
*/
package nand_host_pkg;

  typedef enum logic [3:0] {
    OP_SETUP, OP_CB_SETUP, OP_RAND_IN, OP_DATA_WR, OP_QUEUE, OP_PROGRAM,
    OP_CB_READ, OP_RAND_OUT, OP_DATA_RD, OP_STATUS, OP_STATUS_ENH, OP_RESET
  } op_e;

  typedef enum logic [2:0] {K_CMD, K_ADDR, K_DWR, K_DRD, K_WAIT} kind_e;

  typedef struct packed {
    op_e         op;
    logic [15:0] col;
    logic [23:0] row;
    logic [7:0]  data;
  } req_s;

  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       read_strobe_n;
    logic [7:0] io;
    logic       io_oe_n;
  } pins_s;

endpackage : nand_host_pkg

/* File: design/nand_prog_host.sv */
/*
  Host sequencer for NAND program, two-plane queue and copy back orders.
  Assumes one NAND target on the pins, ready_busy_n_out pulled up outside.
*/
// Contract
// R1: Random data input with new column allowed repeatedly during a page load.
// R2: Queue command loads and queues a plane; final program starts all.
// R3: Plain setup 80h clears page buffers in device unless after queue.
// R4: Queue step is 80h, five address cycles, data, then 11h.
// R5: After 11h device goes busy briefly with status bits 6 and 5 low.
// R6: Host waits ready before queueing more planes or final program.
// R7: Final program writes all planes; host then checks pass/fail per plane. Host reads 70h once into a single resp_fail_o.
// R8: Status bit 0 or 1 flags failure; enhanced status names the plane.
// R9: Plane select low on first address, high on second.
// R10: Column address must be valid within the page for each plane.
// R11: Both planes of one two-plane operation do the same operation type.
// R12: Between 11h and next setup only status, enhanced status or reset.
// R13: Copy back stays in one plane; copy-back read precedes copy-back program.
// R14: Copy-back read is 00h, five source address cycles, 35h, then busy.
// R15: After copy-back read data streams out; random output allowed repeatedly.
// R16: Copy-back program is 85h, five destination addresses, 10h, then busy.
// R17: Random data input may patch copied bytes before program confirm.
// R18: Two-plane copy back equals two-plane program but keeps buffers.
// R19: Two-plane copy-back read moves both planes' pages together.
// R20: Host should check copied data with error correction before programming.
// R21: Status bit 0 gives pass or fail; bit 6 follows ready/busy.
// R22: Device busy for whole program time, accepting only status or reset.
// R23: Device ignores commands not allowed while busy.
`timescale 1ns/1ps
`include "nand_host_regs.svh"
`default_nettype none

module nand_prog_host
  import nand_host_pkg::*;
(
  input  wire logic       clk_i,              // 200 MHz clock
  input  wire logic       rst_i,              // Async reset, active high
  input  wire req_s       req_i,              // Order and its operands
  input  wire logic       req_valid_i,        // Order offered
  output logic            req_ready_o,        // Sequencer idle
  output logic            resp_valid_o,       // Order finished, one cycle
  output logic            resp_err_o,         // Order refused
  output logic            resp_fail_o,        // Program reported failure
  output logic [7:0]      resp_data_o,        // Last byte read from device
  output pins_s           pins_o,             // NAND strobes and data out
  input  wire logic [7:0] io_i,               // NAND data in
  input  wire logic       ready_busy_n_out_i  // Device ready/busy pin
);

  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_LOAD = 7'b0000010,
    S_LOW  = 7'b0000100,
    S_HIGH = 7'b0001000,
    S_WB   = 7'b0010000,
    S_BUSY = 7'b0100000,
    S_DONE = 7'b1000000
  } state_e;

  state_e      state;
  kind_e       seq_kind [`SEQ_LEN];
  logic [7:0]  seq_byte [`SEQ_LEN];
  kind_e       next_kind [`SEQ_LEN];
  logic [7:0]  next_byte [`SEQ_LEN];
  logic [3:0]  seq_len;
  logic [3:0]  next_len;
  logic [3:0]  idx;
  logic [4:0]  cnt;
  logic        rb_meta;
  logic        rb_sync;
  logic [7:0]  io_meta;
  logic [7:0]  io_sync;
  logic        loading;
  logic        load_cb;
  logic        load_plane;
  logic        queued;
  logic        queue_cb;
  logic        cb_ready;
  logic        is_prog;
  logic        ok;
  logic        accept;
  logic [23:0] row_f;
  logic [7:0]  ab [5];
  kind_e       cur_kind;

  assign accept   = req_valid_i && req_ready_o;
  assign cur_kind = seq_kind[idx];

  // Pin inputs cross from the device through two flops each
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      rb_meta <= 1'b0;
      rb_sync <= 1'b0;
      io_meta <= 8'h00;
      io_sync <= 8'h00;
    end
    else
    begin
      rb_meta <= ready_busy_n_out_i;
      rb_sync <= rb_meta;
      io_meta <= io_i;
      io_sync <= io_meta;
    end

  // Second plane address always gets plane select high
  always_comb
  begin
    row_f = req_i.row;
    if (req_i.op == OP_SETUP || req_i.op == OP_CB_SETUP)
      row_f[`PLANE_SEL_POS] = queued; // R9
    ab[0] = req_i.col[7:0];
    ab[1] = req_i.col[15:8];
    ab[2] = row_f[7:0];
    ab[3] = row_f[15:8];
    ab[4] = row_f[23:16];
  end

  // Order legality; refused orders never reach the pins
  always_comb
  begin
    case (req_i.op)
      OP_SETUP:      ok = !loading && !(queued && queue_cb); // R11
      OP_CB_SETUP:   ok = !loading && cb_ready && !(queued && !queue_cb); // R13 R11
      OP_RAND_IN:    ok = loading && req_i.col < `PAGE_BYTES; // R1 R10 R17
      OP_DATA_WR:    ok = loading;
      OP_QUEUE:      ok = loading && !queued && !load_plane; // R9
      OP_PROGRAM:    ok = loading && (!queued || load_plane); // R6
      OP_CB_READ,
      OP_RAND_OUT,
      OP_DATA_RD:    ok = !loading && !queued; // R12
      default:       ok = 1'b1;
    endcase
    if ((req_i.op == OP_SETUP || req_i.op == OP_CB_SETUP || req_i.op == OP_RAND_OUT)
        && req_i.col >= `PAGE_BYTES)
      ok = 1'b0; // R10
  end

  // Pin cycle list for each order
  always_comb
  begin
    for (int i = 0; i < `SEQ_LEN; i++)
    begin
      next_kind[i] = K_WAIT;
      next_byte[i] = 8'h00;
    end
    next_len = 4'd0;
    case (req_i.op)
      OP_SETUP, OP_CB_SETUP:
      begin
        next_kind[0] = K_CMD; // R4 R16
        next_byte[0] = (req_i.op == OP_SETUP) ? `CMD_SERIAL_IN : `CMD_RAND_IN; // R18
        for (int i = 0; i < 5; i++)
        begin
          next_kind[i + 1] = K_ADDR;
          next_byte[i + 1] = ab[i];
        end
        next_len = 4'd6;
      end
      OP_RAND_IN, OP_RAND_OUT:
      begin
        next_kind[0] = K_CMD;
        next_byte[0] = (req_i.op == OP_RAND_IN) ? `CMD_RAND_IN : `CMD_RAND_OUT; // R1 R15
        next_kind[1] = K_ADDR;
        next_byte[1] = ab[0];
        next_kind[2] = K_ADDR;
        next_byte[2] = ab[1];
        next_kind[3] = K_CMD;
        next_byte[3] = `CMD_RAND_OUT_GO;
        next_len = (req_i.op == OP_RAND_IN) ? 4'd3 : 4'd4;
      end
      OP_DATA_WR:
      begin
        next_kind[0] = K_DWR;
        next_byte[0] = req_i.data;
        next_len = 4'd1;
      end
      OP_DATA_RD:
      begin
        next_kind[0] = K_DRD; // R20
        next_len = 4'd1;
      end
      OP_QUEUE:
      begin
        next_kind[0] = K_CMD;
        next_byte[0] = `CMD_QUEUE_GO; // R2 R4
        next_len = 4'd2; // R5
      end
      OP_PROGRAM:
      begin
        next_kind[0] = K_CMD;
        next_byte[0] = `CMD_PROG_GO; // R2 R7
        next_kind[2] = K_CMD;
        next_byte[2] = `CMD_STATUS; // R8
        next_kind[3] = K_DRD;
        next_len = 4'd4;
      end
      OP_CB_READ:
      begin
        next_kind[0] = K_CMD;
        next_byte[0] = `CMD_READ_SETUP; // R14
        for (int i = 0; i < 5; i++)
        begin
          next_kind[i + 1] = K_ADDR;
          next_byte[i + 1] = ab[i];
        end
        next_kind[6] = K_CMD;
        next_byte[6] = `CMD_CB_READ; // R19
        next_len = 4'd8;
      end
      OP_STATUS:
      begin
        next_kind[0] = K_CMD;
        next_byte[0] = `CMD_STATUS;
        next_kind[1] = K_DRD;
        next_len = 4'd2;
      end
      OP_STATUS_ENH:
      begin
        next_kind[0] = K_CMD;
        next_byte[0] = `CMD_STATUS_ENH; // R8
        for (int i = 0; i < 3; i++)
        begin
          next_kind[i + 1] = K_ADDR;
          next_byte[i + 1] = ab[i + 2];
        end
        next_kind[4] = K_DRD;
        next_len = 4'd5;
      end
      default:
      begin
        next_kind[0] = K_CMD;
        next_byte[0] = `CMD_RESET;
        next_len = 4'd2;
      end
    endcase
  end

  // Operation tracking across orders
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      loading    <= 1'b0;
      load_cb    <= 1'b0;
      load_plane <= 1'b0;
      queued     <= 1'b0;
      queue_cb   <= 1'b0;
      cb_ready   <= 1'b0;
    end
    else if (accept && ok)
      case (req_i.op)
        OP_SETUP, OP_CB_SETUP:
        begin
          loading    <= 1'b1;
          load_cb    <= (req_i.op == OP_CB_SETUP);
          load_plane <= row_f[`PLANE_SEL_POS];
        end
        OP_QUEUE:
        begin
          loading  <= 1'b0;
          queued   <= 1'b1;
          queue_cb <= load_cb;
        end
        OP_PROGRAM:
        begin
          loading  <= 1'b0;
          queued   <= 1'b0;
          cb_ready <= 1'b0;
        end
        OP_CB_READ:
          cb_ready <= 1'b1; // R13
        OP_RESET:
        begin
          loading  <= 1'b0;
          queued   <= 1'b0;
          cb_ready <= 1'b0;
        end
        default:
          loading <= loading;
      endcase

  // Cycle sequencer
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      state        <= S_IDLE;
      idx          <= 4'd0;
      cnt          <= 5'd0;
      seq_len      <= 4'd0;
      is_prog      <= 1'b0;
      req_ready_o  <= 1'b1;
      resp_valid_o <= 1'b0;
      resp_err_o   <= 1'b0;
      resp_fail_o  <= 1'b0;
      resp_data_o  <= 8'h00;
      pins_o       <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                        read_strobe_n: 1'b1, io: 8'h00, io_oe_n: 1'b1};
      for (int i = 0; i < `SEQ_LEN; i++)
      begin
        seq_kind[i] <= K_WAIT;
        seq_byte[i] <= 8'h00;
      end
    end
    else
    begin
      resp_valid_o <= 1'b0;
      case (state)
        S_IDLE:
          if (accept)
          begin
            resp_fail_o <= 1'b0;
            if (ok)
            begin
              for (int i = 0; i < `SEQ_LEN; i++)
              begin
                seq_kind[i] <= next_kind[i];
                seq_byte[i] <= next_byte[i];
              end
              seq_len     <= next_len;
              is_prog     <= (req_i.op == OP_PROGRAM);
              idx         <= 4'd0;
              req_ready_o <= 1'b0;
              resp_err_o  <= 1'b0;
              state       <= S_LOAD;
            end
            else
            begin
              resp_err_o   <= 1'b1;
              resp_valid_o <= 1'b1;
            end
          end
        S_LOAD:
          if (idx == seq_len)
            state <= S_DONE;
          else if (cur_kind == K_WAIT)
          begin
            cnt   <= `WB_CYC;
            state <= S_WB;
          end
          else
          begin
            pins_o.ce_n    <= 1'b0;
            pins_o.cle     <= (cur_kind == K_CMD);
            pins_o.ale     <= (cur_kind == K_ADDR);
            pins_o.io      <= seq_byte[idx];
            pins_o.io_oe_n <= (cur_kind == K_DRD);
            if (cur_kind == K_DRD)
            begin
              pins_o.read_strobe_n <= 1'b0;
              cnt                  <= `RD_LOW_CYC;
            end
            else
            begin
              pins_o.we_n <= 1'b0;
              cnt         <= `WE_LOW_CYC;
            end
            state <= S_LOW;
          end
        S_LOW:
          if (cnt == 5'd1)
          begin
            // Read data sampled after sync delay, while strobe still low
            if (cur_kind == K_DRD)
              resp_data_o <= io_sync;
            pins_o.we_n          <= 1'b1;
            pins_o.read_strobe_n <= 1'b1;
            cnt   <= (cur_kind == K_DRD) ? `RD_HIGH_CYC : `WE_HIGH_CYC;
            state <= S_HIGH;
          end
          else
            cnt <= cnt - 5'd1;
        S_HIGH:
          if (cnt == 5'd1)
          begin
            pins_o.cle     <= 1'b0;
            pins_o.ale     <= 1'b0;
            pins_o.io_oe_n <= 1'b1;
            idx            <= idx + 4'd1;
            state          <= S_LOAD;
          end
          else
            cnt <= cnt - 5'd1;
        S_WB:
          // Ready/busy is watched only after the write-to-busy delay
          if (cnt == 5'd1)
            state <= S_BUSY;
          else
            cnt <= cnt - 5'd1;
        S_BUSY:
          if (rb_sync) // R5 R6 R14 R16 R22
          begin
            idx   <= idx + 4'd1;
            state <= S_LOAD;
          end
        default:
        begin
          pins_o.ce_n  <= 1'b1;
          resp_fail_o  <= is_prog && |(resp_data_o & `STATUS_FAIL_MSK); // R7 R8 R21
          resp_valid_o <= 1'b1;
          req_ready_o  <= 1'b1;
          state        <= S_IDLE;
        end
      endcase
    end

endmodule : nand_prog_host

`default_nettype wire

/* File: verif/nand_host_props.sv */
/* Checker for the NAND host sequencer: strobe timing, order handshake, busy.
   Assumes the sequencer strobe counts and a bind onto nand_prog_host. */
`timescale 1ns/1ps
`default_nettype none
module nand_host_props
  import nand_host_pkg::*;
(
  input wire logic  clk_i,              // Clock
  input wire logic  rst_i,              // Reset
  input wire logic  req_valid_i,        // Order offered
  input wire logic  req_ready_o,        // Idle
  input wire logic  resp_valid_o,       // Order ended
  input wire logic  resp_err_o,         // Order refused
  input wire pins_s pins_o,             // NAND pins
  input wire logic  ready_busy_n_out_i  // Device ready
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence we_pulse;
    !pins_o.we_n [*5] ##1 pins_o.we_n;
  endsequence
  sequence rd_pulse;
    !pins_o.read_strobe_n [*7] ##1 pins_o.read_strobe_n;
  endsequence
  we_low_time_a: assert property ($fell(pins_o.we_n) |-> we_pulse)
    else $error("we_n low time wrong");
  we_high_time_a: assert property ($rose(pins_o.we_n) |-> pins_o.we_n [*3])
    else $error("we_n high time short");
  rd_low_time_a: assert property ($fell(pins_o.read_strobe_n) |-> rd_pulse)
    else $error("read strobe low time wrong");
  strobes_apart_a: assert property (!(!pins_o.we_n && !pins_o.read_strobe_n))
    else $error("both strobes low");
  latch_excl_a: assert property (!(pins_o.cle && pins_o.ale))
    else $error("cle and ale together");
  write_drives_a: assert property (!pins_o.we_n |-> !pins_o.io_oe_n && !pins_o.ce_n)
    else $error("write cycle without drive");
  busy_no_write_a: assert property (!ready_busy_n_out_i |-> !$fell(pins_o.we_n))
    else $error("write started while busy");
  refuse_quiet_a: assert property (resp_valid_o && resp_err_o |->
    pins_o.ce_n && $past(pins_o.ce_n))
    else $error("refused order touched pins");
  resp_pulse_a: assert property (resp_valid_o |=> !resp_valid_o)
    else $error("response longer than one cycle");
  accept_busy_a: assert property (req_valid_i && req_ready_o |=>
    !req_ready_o || resp_valid_o)
    else $error("ready stayed after accept");
endmodule : nand_host_props
bind nand_prog_host nand_host_props chk_i (
  .clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
  .req_ready_o(req_ready_o), .resp_valid_o(resp_valid_o), .resp_err_o(resp_err_o),
  .pins_o(pins_o), .ready_busy_n_out_i(ready_busy_n_out_i)
);
`default_nettype wire

/* File: verif/nand_dev_model.sv */
/* Behavioural NAND target: command latch, small page buffer, busy timing.
   Assumes registered host pins; the clock times busy periods and samples strobe edges. */
`timescale 1ns/1ps
`include "nand_host_regs.svh"
`default_nettype none
module nand_dev_model
  import nand_host_pkg::*;
(
  input  wire logic  clk_i,  // Time base
  input  wire pins_s pins_i, // Host pins
  input  wire logic  fail_i, // Next program fails
  output logic [7:0] io_o,   // Device data out
  output logic       rb_n_o  // Ready/busy, 1 = ready
);
  logic [7:0] buf_m [16];
  logic [7:0] cmd = 8'h00, last = 8'h00, busy = 8'h00, val;
  logic [3:0] col = 4'h0;
  logic [2:0] acnt = 3'h0;
  logic [1:0] pl_m = 2'h0;
  logic       fail = 1'b0, queued = 1'b0, we_q = 1'b1, rs_q = 1'b1, stat;
  initial foreach (buf_m[i]) buf_m[i] = 8'hff;
  assign rb_n_o = (busy == 8'h00);
  assign stat = cmd inside {8'h70, 8'h78};
  assign val = stat ? {1'b1, rb_n_o, rb_n_o, 4'h0, fail} : buf_m[col];
  // Released bus shows the inverse of its last value, never a stale copy
  assign io_o = pins_i.read_strobe_n ? ~last : val;
  always @(posedge clk_i)
  begin
    we_q <= pins_i.we_n;
    rs_q <= pins_i.read_strobe_n;
    if (busy != 8'h00) busy <= busy - 8'h01;
    if (!pins_i.read_strobe_n) last <= val;
    if (pins_i.read_strobe_n && !rs_q && !stat) col <= col + 4'h1;
    if (pins_i.we_n && !we_q && !pins_i.ce_n)
    begin
      if (pins_i.cle && (rb_n_o || pins_i.io inside {8'h70, 8'h78, 8'hff}))
      begin
        cmd <= pins_i.io;
        acnt <= 3'h0;
        case (pins_i.io)
          8'h80: if (!queued) foreach (buf_m[i]) buf_m[i] <= 8'hff;
          8'h11: begin queued <= 1'b1; busy <= 8'h1e; end
          8'h10: begin queued <= 1'b0; fail <= fail_i; busy <= 8'hc8; end
          8'h35: busy <= 8'h3c;
          8'hff: begin queued <= 1'b0; busy <= 8'h28; end
          default: ;
        endcase
      end
      else if (pins_i.ale)
      begin
        if (acnt == 3'h0) col <= pins_i.io[3:0];
        if (acnt == 3'h2) pl_m <= {pl_m[0], pins_i.io[`PLANE_SEL_POS]};
        acnt <= acnt + 3'h1;
      end
      else if (!pins_i.cle)
      begin
        buf_m[col] <= pins_i.io;
        col <= col + 4'h1;
      end
    end
  end
endmodule : nand_dev_model
`default_nettype wire

/* File: verif/nand_prog_host_tb.sv */
/* Self-checking bench: orders in sequence against the device model.
   Assumes nand_dev_model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`include "nand_host_regs.svh"
`default_nettype none
module nand_prog_host_tb
  import nand_host_pkg::*;
;
  logic       clk_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0, fail_i = 1'b0;
  req_s       req_i = '0;
  logic       req_ready_o, resp_valid_o, resp_err_o, resp_fail_o, rb_n;
  logic [7:0] resp_data_o, dev_io;
  pins_s      pins_o;
  int         err_total = 0;
  int         compares = 0;
  op_e        refuse [5] = '{OP_RAND_IN, OP_DATA_WR, OP_QUEUE, OP_PROGRAM, OP_CB_SETUP};
  wire logic [7:0] io_i = pins_o.io_oe_n ? dev_io : pins_o.io;
  initial forever #2.5 clk_i = ~clk_i;
  nand_prog_host DUT (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .resp_valid_o(resp_valid_o), .resp_err_o(resp_err_o),
    .resp_fail_o(resp_fail_o), .resp_data_o(resp_data_o), .pins_o(pins_o),
    .io_i(io_i), .ready_busy_n_out_i(rb_n)
  );
  nand_dev_model m (
    .clk_i(clk_i), .pins_i(pins_o), .fail_i(fail_i), .io_o(dev_io), .rb_n_o(rb_n)
  );
  task automatic final_report;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic run(input op_e op, input logic [15:0] c, input logic [23:0] r,
                     input logic [7:0] d, input logic er);
    int n;
    n = 0;
    @(posedge clk_i);
    #1;
    req_i = '{op, c, r, d};
    req_valid_i = 1'b1;
    // Ready is looked at off the edge, so the accept edge is never raced
    while (req_ready_o !== 1'b1 && n < 2000)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    @(posedge clk_i);
    #1;
    req_valid_i = 1'b0;
    while (resp_valid_o !== 1'b1 && n < 2000)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 2000)
    begin
      err_total++;
      final_report();
    end
    else
      chk("resp_err_o", {7'h0, er}, {7'h0, resp_err_o});
  endtask : run
  initial
  begin
    repeat (8) @(posedge clk_i);
    #1 rst_i = 1'b0;
    // Nothing is loading and no copy-back read is done yet, so each of these must be refused
    foreach (refuse[i]) run(refuse[i], 16'h0000, 24'h0, 8'h00, 1'b1);
    run(OP_SETUP, `PAGE_BYTES, 24'h0, 8'h00, 1'b1);
    run(OP_SETUP, 16'h0002, 24'h000140, 8'h00, 1'b0);
    run(OP_DATA_WR, 16'h0, 24'h0, 8'ha1, 1'b0);
    run(OP_RAND_IN, 16'h0005, 24'h0, 8'h00, 1'b0);
    run(OP_DATA_WR, 16'h0, 24'h0, 8'ha2, 1'b0);
    run(OP_QUEUE, 16'h0, 24'h0, 8'h00, 1'b0);
    run(OP_CB_READ, 16'h0, 24'h0, 8'h00, 1'b1);
    run(OP_CB_SETUP, 16'h0, 24'h0, 8'h00, 1'b1);
    run(OP_SETUP, 16'h0000, 24'h000100, 8'h00, 1'b0);
    run(OP_DATA_WR, 16'h0, 24'h0, 8'hb1, 1'b0);
    run(OP_PROGRAM, 16'h0, 24'h0, 8'h00, 1'b0);
    chk("resp_fail_o", 8'h00, {7'h0, resp_fail_o});
    chk("plane bits", 8'h01, {6'h0, m.pl_m});
    chk("buf 2", 8'ha1, m.buf_m[2]);
    chk("buf 5", 8'ha2, m.buf_m[5]);
    chk("buf 0", 8'hb1, m.buf_m[0]);
    fail_i = 1'b1;
    run(OP_SETUP, 16'h0002, 24'h0, 8'h00, 1'b0);
    run(OP_DATA_WR, 16'h0, 24'h0, 8'h5a, 1'b0);
    run(OP_PROGRAM, 16'h0, 24'h0, 8'h00, 1'b0);
    chk("resp_fail_o", 8'h01, {7'h0, resp_fail_o});
    fail_i = 1'b0;
    run(OP_STATUS, 16'h0, 24'h0, 8'h00, 1'b0);
    chk("status", 8'he1, resp_data_o);
    run(OP_STATUS_ENH, 16'h0, 24'h0, 8'h00, 1'b0);
    chk("status enh", 8'he1, resp_data_o);
    run(OP_CB_READ, 16'h0002, 24'h000010, 8'h00, 1'b0);
    run(OP_DATA_RD, 16'h0, 24'h0, 8'h00, 1'b0);
    chk("rd col 2", 8'h5a, resp_data_o);
    run(OP_DATA_RD, 16'h0, 24'h0, 8'h00, 1'b0);
    chk("rd col 3", 8'hff, resp_data_o);
    run(OP_RAND_OUT, 16'h0002, 24'h0, 8'h00, 1'b0);
    run(OP_DATA_RD, 16'h0, 24'h0, 8'h00, 1'b0);
    chk("rd again", 8'h5a, resp_data_o);
    run(OP_CB_SETUP, 16'h0003, 24'h000020, 8'h00, 1'b0);
    run(OP_RAND_IN, 16'h0004, 24'h0, 8'h00, 1'b0);
    run(OP_DATA_WR, 16'h0, 24'h0, 8'h3c, 1'b0);
    run(OP_PROGRAM, 16'h0, 24'h0, 8'h00, 1'b0);
    chk("resp_fail_o", 8'h00, {7'h0, resp_fail_o});
    chk("kept 2", 8'h5a, m.buf_m[2]);
    chk("patch 4", 8'h3c, m.buf_m[4]);
    run(OP_RESET, 16'h0, 24'h0, 8'h00, 1'b0);
    final_report();
  end
endmodule : nand_prog_host_tb
`default_nettype wire
